// [hw/ufl_fifo_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - The receive threshold nibble sets the receive trigger level to its value for codes 0 to 14, and code 15 is reserved.
// - The transmit threshold nibble sets the transmit trigger level to its value for codes 1 to 15.
// - A zero baud divisor with the port disabled empties both FIFOs.
// - That clear also drops the receive overflow, receive underflow and transmit overflow flags.
// - That clear also returns the LIN counter to zero.
// - Each FIFO holds up to fifteen bytes, so levels run from zero to fifteen.
// - Receive data available is raised while the receive level exceeds the receive threshold.
// - With the port enabled, queued transmit bytes go out and received bytes are stored.
module ufl_fifo_ctrl
    import ufl_pkg::*;
(
    input  wire logic        clk_i,       // System clock, 100 MHz
    input  wire logic        rst_i,       // Sync reset, high
    input  wire logic        cyc_i,       // Wishbone cycle
    input  wire logic        stb_i,       // Wishbone strobe
    input  wire logic        we_i,        // Wishbone write enable
    input  wire logic [31:0] adr_i,       // Wishbone byte address
    input  wire logic [3:0]  sel_i,       // Wishbone byte selects
    input  wire logic [31:0] dat_i,       // Wishbone write data
    output logic      [31:0] dat_o,       // Wishbone read data
    output logic             ack_o,       // Wishbone acknowledge
    output logic      [7:0]  tx_data_o,   // Byte to serialiser
    output logic             tx_valid_o,  // Byte available to send
    input  wire logic        tx_ready_i,  // Serialiser takes byte
    input  wire ufl_byte_t   rx_byte_i,   // Received byte strobe
    output logic             tx_ready_lvl_o, // Tx level below threshold
    output logic             irq_o        // Level interrupt
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic [3:0]  rx_thr;
        logic [3:0]  tx_thr;
        logic [15:0] baud;
        logic        en;
        logic [3:0]  istat;
        logic [3:0]  ien;
        logic [7:0]  lin;
    } ufl_st_t;

    ufl_st_t          st_reg;
    ufl_st_t          st_next;
    logic [IDX_W-1:0] idx;
    logic             req;
    logic             wr_done;
    logic             rd_done;
    logic             clear_fifo;
    logic [7:0]       rx_head;
    logic [CNT_W-1:0] rx_cnt;
    logic [CNT_W-1:0] tx_cnt;
    logic             rx_full;
    logic             rx_empty;
    logic             tx_full;
    logic             tx_empty;
    logic             rx_push;
    logic             rx_pop;
    logic             tx_push;
    logic             tx_pop;
    logic             rda_lvl;
    logic [3:0]       ev;
    logic [3:0]       clr;
    logic             reg_wr;
    logic             lin_inc;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // A write or a pop lands on the ack edge, while the master still
    // holds the request; read data was captured one edge earlier.
    assign idx     = adr_i[IDX_W+1:2];
    assign req     = cyc_i && stb_i;
    assign wr_done = req && st_reg.ack && we_i;
    assign rd_done = req && st_reg.ack && !we_i;
    assign reg_wr  = wr_done && sel_i[0];
    // Clear is a level: both FIFOs stay empty for as long as the
    // divisor is zero and the port is off.
    assign clear_fifo = (st_reg.baud == BAUD_RST) && !st_reg.en;

    // ------------------------------------------------------------
    // FIFOs and link
    // ------------------------------------------------------------
    assign tx_valid_o = st_reg.en && !tx_empty;
    assign tx_pop     = tx_valid_o && tx_ready_i;
    assign rx_push    = rx_byte_i.valid && st_reg.en;
    assign tx_push    = reg_wr && (idx == IDX_DATA);
    assign rx_pop     = rd_done && (idx == IDX_DATA);
    // Only bytes that really enter the receive FIFO are counted
    assign lin_inc    = rx_push && !rx_full;

    ufl_fifo u_tx_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .flush_i     (clear_fifo),
        .push_i      (tx_push),
        .push_data_i (dat_i[7:0]),
        .pop_i       (tx_pop),
        .head_o      (tx_data_o),
        .count_o     (tx_cnt),
        .full_o      (tx_full),
        .empty_o     (tx_empty)
    );

    ufl_fifo u_rx_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .flush_i     (clear_fifo),
        .push_i      (rx_push),
        .push_data_i (rx_byte_i.data),
        .pop_i       (rx_pop),
        .head_o      (rx_head),
        .count_o     (rx_cnt),
        .full_o      (rx_full),
        .empty_o     (rx_empty)
    );

    // ------------------------------------------------------------
    // Trigger levels
    // ------------------------------------------------------------
    // Code 15 can never be exceeded, so the reserved code never fires
    assign rda_lvl = (rx_cnt > st_reg.rx_thr);
    assign tx_ready_lvl_o = (tx_cnt < st_reg.tx_thr);

    // ------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------
    always_comb begin
        ev          = '0;
        // Set would win over the clear, so the overflow and underflow events are held off during a clear
        ev[INT_RFO] = rx_push && rx_full && !clear_fifo;
        ev[INT_RFU] = rx_pop && rx_empty && !clear_fifo;
        ev[INT_TFO] = tx_push && tx_full && !clear_fifo;
        ev[INT_RDA] = rda_lvl;
        clr         = '0;
        if (reg_wr && (idx == IDX_INT_CLR)) begin
            clr = dat_i[INT_W-1:0];
        end
        if (clear_fifo) begin
            clr[INT_RFO] = 1'b1;
            clr[INT_RFU] = 1'b1;
            clr[INT_TFO] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Interrupt line and bus outputs
    // ------------------------------------------------------------
    assign irq_o = |(st_reg.istat & st_reg.ien);
    assign ack_o = st_reg.ack;
    assign dat_o = st_reg.rdata;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    always_comb begin
        st_next       = st_reg;
        // One-cycle ack; a strobe held on gets a fresh ack every other cycle
        st_next.ack   = req && !st_reg.ack;
        // Set wins over a simultaneous clear
        st_next.istat = (st_reg.istat & ~clr) | ev;
        if (lin_inc) begin
            st_next.lin = st_reg.lin + 8'h01;
        end
        if (clear_fifo) begin
            st_next.lin = LIN_RST;
        end
        if (req && !st_reg.ack) begin
            st_next.rdata = '0;
            unique case (idx)
                IDX_DATA:     st_next.rdata[7:0] = rx_head;
                IDX_CTRL:     st_next.rdata[CTRL_EN_BIT] = st_reg.en;
                IDX_BAUD_LO:  st_next.rdata[7:0] = st_reg.baud[7:0];
                IDX_BAUD_HI:  st_next.rdata[7:0] = st_reg.baud[15:8];
                IDX_LEVEL:    st_next.rdata[7:0] = {rx_cnt, tx_cnt};
                IDX_INT_STAT: st_next.rdata[INT_W-1:0] = st_reg.istat;
                IDX_INT_EN:   st_next.rdata[INT_W-1:0] = st_reg.ien;
                IDX_LIN:      st_next.rdata[7:0] = st_reg.lin;
                default:      st_next.rdata = '0;
            endcase
        end
        if (reg_wr) begin
            unique case (idx)
                IDX_CTRL:    st_next.en = dat_i[CTRL_EN_BIT];
                IDX_BAUD_LO: st_next.baud[7:0] = dat_i[7:0];
                IDX_BAUD_HI: st_next.baud[15:8] = dat_i[7:0];
                // Levels are read-only; a write here moves only the thresholds
                IDX_LEVEL: begin
                    st_next.rx_thr = dat_i[RX_NIB_LSB +: 4];
                    st_next.tx_thr = dat_i[TX_NIB_LSB +: 4];
                end
                IDX_INT_EN:  st_next.ien = dat_i[INT_W-1:0];
                default:     st_next.en = st_reg.en;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg        <= '0;
            st_reg.rx_thr <= THR_RST;
            st_reg.tx_thr <= THR_RST;
            st_reg.baud   <= BAUD_RST;
            st_reg.istat  <= INT_RST;
            st_reg.ien    <= INT_RST;
            st_reg.lin    <= LIN_RST;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule : ufl_fifo_ctrl
`default_nettype wire

// [shared/ufl_pkg.sv]
package ufl_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int          FIFO_DEPTH = 15;
    localparam int          DATA_W     = 8;
    localparam int          CNT_W      = 4;
    localparam int          IDX_W      = 10;

    // ------------------------------------------------------------
    // Register indices (byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [9:0]  IDX_DATA     = 10'h0a0;
    localparam logic [9:0]  IDX_CTRL     = 10'h0a1;
    localparam logic [9:0]  IDX_BAUD_LO  = 10'h0a2;
    localparam logic [9:0]  IDX_BAUD_HI  = 10'h0a3;
    localparam logic [9:0]  IDX_LEVEL    = 10'h0a5;
    localparam logic [9:0]  IDX_INT_STAT = 10'h0a6;
    localparam logic [9:0]  IDX_INT_EN   = 10'h0a7;
    localparam logic [9:0]  IDX_INT_CLR  = 10'h0a8;
    localparam logic [9:0]  IDX_LIN      = 10'h0a9;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          CTRL_EN_BIT  = 7;
    localparam int          RX_NIB_LSB   = 4;
    localparam int          TX_NIB_LSB   = 0;
    localparam int          INT_RFO      = 0;
    localparam int          INT_RFU      = 1;
    localparam int          INT_TFO      = 2;
    localparam int          INT_RDA      = 3;
    localparam int          INT_W        = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0]  THR_RST      = 4'h0;
    localparam logic [15:0] BAUD_RST     = 16'h0000;
    localparam logic [7:0]  LIN_RST      = 8'h00;
    localparam logic [3:0]  INT_RST      = 4'h0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic [7:0]  data;
    } ufl_byte_t;

endpackage : ufl_pkg

// [hw/ufl_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module ufl_fifo
    import ufl_pkg::*;
(
    input  wire logic              clk_i,       // System clock
    input  wire logic              rst_i,       // Sync reset, high
    input  wire logic              flush_i,     // Empty the FIFO
    input  wire logic              push_i,      // Write request
    input  wire logic [DATA_W-1:0] push_data_i, // Write data
    input  wire logic              pop_i,       // Read request
    output logic      [DATA_W-1:0] head_o,      // Oldest byte
    output logic      [CNT_W-1:0]  count_o,     // Fill level
    output logic                   full_o,      // Level is FIFO_DEPTH
    output logic                   empty_o      // Level is zero
);

    typedef struct packed {
        logic [FIFO_DEPTH-1:0][DATA_W-1:0] mem;
        logic [CNT_W-1:0]                  wptr;
        logic [CNT_W-1:0]                  rptr;
        logic [CNT_W-1:0]                  cnt;
    } ufl_fifo_st_t;

    localparam logic [CNT_W-1:0] LAST  = CNT_W'(FIFO_DEPTH - 1);
    localparam logic [CNT_W-1:0] FULLC = CNT_W'(FIFO_DEPTH);
    localparam logic [CNT_W-1:0] ONE   = 4'h1;
    localparam logic [CNT_W-1:0] ZERO  = 4'h0;

    ufl_fifo_st_t st_reg;
    ufl_fifo_st_t st_next;
    logic         do_push;
    logic         do_pop;

    assign full_o  = (st_reg.cnt == FULLC);
    assign empty_o = (st_reg.cnt == ZERO);
    assign count_o = st_reg.cnt;
    assign head_o  = st_reg.mem[st_reg.rptr];
    assign do_push = push_i && !full_o;
    assign do_pop  = pop_i && !empty_o;

    always_comb begin
        st_next = st_reg;
        if (flush_i) begin
            st_next.wptr = ZERO;
            st_next.rptr = ZERO;
            st_next.cnt  = ZERO;
        end else begin
            if (do_push) begin
                st_next.mem[st_reg.wptr] = push_data_i;
                st_next.wptr = (st_reg.wptr == LAST) ? ZERO
                                                     : st_reg.wptr + ONE;
            end
            if (do_pop) begin
                st_next.rptr = (st_reg.rptr == LAST) ? ZERO
                                                     : st_reg.rptr + ONE;
            end
            if (do_push && !do_pop) begin
                st_next.cnt = st_reg.cnt + ONE;
            end else if (do_pop && !do_push) begin
                st_next.cnt = st_reg.cnt - ONE;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule : ufl_fifo
`default_nettype wire

// [verification/ufl_fifo_ctrl_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module ufl_fifo_ctrl_chk
    import ufl_pkg::*;
(
    input wire logic        clk_i,          // Clock
    input wire logic        rst_i,          // Reset
    input wire logic        cyc_i,          // Cycle
    input wire logic        stb_i,          // Strobe
    input wire logic        we_i,           // Write enable
    input wire logic [31:0] adr_i,          // Address
    input wire logic [3:0]  sel_i,          // Selects
    input wire logic [31:0] dat_i,          // Write data
    input wire logic [31:0] dat_o,          // Read data
    input wire logic        ack_o,          // Acknowledge
    input wire logic [7:0]  tx_data_o,      // Tx byte
    input wire logic        tx_valid_o,     // Tx valid
    input wire logic        tx_ready_i,     // Tx ready
    input wire logic        tx_ready_lvl_o  // Tx below threshold
);
    // ------------------------------------------------------------
    // Shadow of enable, divisor and tx threshold
    // ------------------------------------------------------------
    logic       en_reg, lo_reg, hi_reg;
    logic [3:0] thr_reg;
    wire logic [9:0] ix  = adr_i[11:2];
    wire logic       wr  = cyc_i & stb_i & we_i & ack_o & sel_i[0];
    wire logic       clr = !en_reg & !lo_reg & !hi_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_reg  <= 1'h0;
            lo_reg  <= 1'h0;
            hi_reg  <= 1'h0;
            thr_reg <= 4'h0;
        end else if (wr) begin
            if (ix == IDX_CTRL) en_reg <= dat_i[CTRL_EN_BIT];
            if (ix == IDX_BAUD_LO) lo_reg <= |dat_i[7:0];
            if (ix == IDX_BAUD_HI) hi_reg <= |dat_i[7:0];
            if (ix == IDX_LEVEL) thr_reg <= dat_i[3:0];
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence rd_req(logic [9:0] x);
        cyc_i && stb_i && !we_i && !ack_o && ix == x;
    endsequence
    AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
        else $error("ack too long");
    AST_RD_UPPER: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0)
        else $error("upper read bits set");
    AST_CLR_LEVEL: assert property (rd_req(IDX_LEVEL) ##0 clr |=> dat_o[7:0] == 8'h00)
        else $error("levels not zero in clear");
    AST_CLR_FLAGS: assert property (rd_req(IDX_INT_STAT) ##0 clr |=> dat_o[2:0] == 3'h0)
        else $error("flags not zero in clear");
    AST_CLR_LIN: assert property (rd_req(IDX_LIN) ##0 clr |=> dat_o[7:0] == 8'h00)
        else $error("lin counter not zero in clear");
    AST_TX_OFF: assert property (!en_reg |-> !tx_valid_o)
        else $error("tx valid while disabled");
    AST_TX_HOLD: assert property (tx_valid_o && !tx_ready_i && !ack_o |=> tx_valid_o && $stable(tx_data_o))
        else $error("tx byte dropped");
    AST_TX_THR0: assert property (thr_reg == 4'h0 |-> !tx_ready_lvl_o)
        else $error("tx ready with code zero");
    AST_TX_EMPTY: assert property (clr && $past(clr) && thr_reg != 4'h0
        |-> tx_ready_lvl_o) else $error("tx not ready when empty");
endmodule : ufl_fifo_ctrl_chk
bind ufl_fifo_ctrl ufl_fifo_ctrl_chk i_chk (.clk_i, .rst_i, .cyc_i, .stb_i,
    .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .tx_data_o, .tx_valid_o,
    .tx_ready_i, .tx_ready_lvl_o);
`default_nettype wire

// [verification/uart_fifo_level_threshold_test.sv]
`timescale 1ns/1ps
`default_nettype none
module uart_fifo_level_threshold_test
    import ufl_pkg::*;
;
    logic        clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0;
    logic        we_i = 1'h0, tx_ready_i = 1'h0;
    logic [31:0] adr_i = 32'h0, dat_i = 32'h0, dat_o;
    logic [3:0]  sel_i = 4'h0;
    ufl_byte_t   rx_byte_i = 9'h000;
    logic        ack_o, tx_valid_o, tx_ready_lvl_o, irq_o;
    logic [7:0]  tx_data_o, r, b;
    int          error_cnt = 0, check_count = 0, cyc_cnt = 0, seed = 67;
    int          i, t;
    logic [7:0]  q[$];
    always #5 clk_i = ~clk_i;
    ufl_fifo_ctrl i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
        .sel_i, .dat_i, .dat_o, .ack_o, .tx_data_o, .tx_valid_o, .tx_ready_i,
        .rx_byte_i, .tx_ready_lvl_o, .irq_o);
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic end_of_test;
        if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [9:0] x, input logic [7:0] d);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, sel_i} <= {2'h3, w, 4'h1};
        adr_i <= {20'h0, x, 2'h0};
        dat_i <= {24'h0, d};
        @(posedge clk_i);
        while (ack_o !== 1'h1) @(posedge clk_i);
        r = dat_o[7:0];
        {cyc_i, stb_i} <= 2'h0;
    endtask : wb
    task automatic push(input logic [7:0] d);
        @(posedge clk_i);
        rx_byte_i <= {1'h1, d};
        @(posedge clk_i);
        rx_byte_i <= 9'h000;
    endtask : push
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    always @(posedge clk_i) if (++cyc_cnt == 8000) begin
        error_cnt++;
        end_of_test;
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        wb(1'h0, IDX_LEVEL, 8'h00); chk(r, 8'h00);
        wb(1'h0, 10'h3ff, 8'h00); chk(r, 8'h00);
        wb(1'h1, IDX_INT_EN, 8'h08);
        for (t = 0; t < 15; t++) begin
            wb(1'h1, IDX_BAUD_LO, 8'($random(seed)) | 8'h01);
            push(8'($random(seed)));
            wb(1'h1, IDX_CTRL, 8'h80);
            wb(1'h1, IDX_LEVEL, {4'(t), 4'(t + 1)});
            wb(1'h0, IDX_LEVEL, 8'h00); chk(r, 8'h00);
            chk(tx_ready_lvl_o, 8'h01);
            for (i = 0; i <= t; i++) begin
                wb(1'h0, IDX_INT_STAT, 8'h00); chk(r[INT_RDA], 8'h00);
                chk(irq_o, 8'h00);
                push(8'($random(seed)));
            end
            wb(1'h0, IDX_INT_STAT, 8'h00); chk(r[INT_RDA], 8'h01);
            chk(irq_o, 8'h01);
            wb(1'h0, IDX_LEVEL, 8'h00); chk(r, {4'(t + 1), 4'h0});
            wb(1'h0, IDX_LIN, 8'h00); chk(r, 8'(t + 1));
            wb(1'h1, IDX_CTRL, 8'h00);
            wb(1'h1, IDX_BAUD_LO, 8'h00);
            wb(1'h0, IDX_LEVEL, 8'h00); chk(r, 8'h00);
            wb(1'h0, IDX_LIN, 8'h00); chk(r, 8'h00);
            wb(1'h1, IDX_INT_CLR, 8'h0f);
        end
        wb(1'h1, IDX_BAUD_LO, 8'h5a);
        wb(1'h1, IDX_CTRL, 8'h80);
        wb(1'h1, IDX_LEVEL, 8'h05);
        for (i = 0; i < 16; i++) begin
            b = 8'($random(seed));
            if (i < 15) q.push_back(b);
            push(b);
        end
        wb(1'h0, IDX_LEVEL, 8'h00); chk(r, 8'hf0);
        wb(1'h1, IDX_INT_EN, 8'h00);
        wb(1'h0, IDX_INT_STAT, 8'h00); chk(r[3:0], 8'h09);
        chk(irq_o, 8'h00);
        while (q.size() > 0) begin
            wb(1'h0, IDX_DATA, 8'h00); chk(r, q.pop_front());
        end
        wb(1'h0, IDX_DATA, 8'h00);
        for (i = 0; i < 16; i++) begin
            wb(1'h0, IDX_LEVEL, 8'h00); chk(r[3:0], 8'(i > 15 ? 15 : i));
            chk(tx_ready_lvl_o, 8'(i < 5));
            chk(tx_valid_o, 8'(i > 0));
            b = 8'($random(seed));
            if (i < 15) q.push_back(b);
            wb(1'h1, IDX_DATA, b);
        end
        @(posedge clk_i);
        tx_ready_i <= 1'h1;
        while (q.size() > 0) begin
            @(posedge clk_i);
            if (tx_valid_o === 1'h1) chk(tx_data_o, q.pop_front());
        end
        tx_ready_i <= 1'h0;
        wb(1'h0, IDX_INT_STAT, 8'h00); chk(r[2:0], 8'h07);
        chk(tx_valid_o, 8'h00);
        wb(1'h1, IDX_CTRL, 8'h00);
        wb(1'h1, IDX_BAUD_LO, 8'h00);
        wb(1'h0, IDX_INT_STAT, 8'h00); chk(r[2:0], 8'h00);
        end_of_test;
    end
endmodule : uart_fifo_level_threshold_test
`default_nettype wire
